// [core/hsf_pkg.sv]
package hsf_pkg;
  // Comparator and strap inputs, index into the raw input vector
  localparam int HSF_CMP_W = 14;
  localparam int IX_POR = 0;
  localparam int IX_UV_OK = 1;
  localparam int IX_OV_HI = 2;
  localparam int IX_TMR_HI = 3;
  localparam int IX_TMR_MID = 4;
  localparam int IX_TMR_LOW = 5;
  localparam int IX_ILIM = 6;
  localparam int IX_PLIM = 7;
  localparam int IX_CB = 8;
  localparam int IX_PGOOD = 9;
  localparam int IX_RETRY_N = 10;
  localparam int IX_CL_PIN = 11;
  localparam int IX_CB_PIN = 12;
  localparam int IX_ALERT = 13;

  // Register command codes
  localparam logic [7:0] ADDR_INPUT_FAULT = 8'h7c;
  localparam logic [7:0] ADDR_VENDOR_FAULT = 8'h80;
  localparam logic [7:0] ADDR_ALERT_MASK = 8'hd8;
  localparam logic [7:0] ADDR_SETUP = 8'hd9;
  localparam logic [7:0] ADDR_COMBINED = 8'he1;

  // Bit positions: combined word and alert mask share one layout
  localparam int B_CP_FAULT = 0;
  localparam int B_BREAKER_FAULT_FLAG = 1;
  localparam int B_UV_FAULT = 2;
  localparam int B_OV_FAULT = 3;
  localparam int B_LATCHED = 4;
  localparam int B_PGOOD = 5;
  localparam int B_PRESET = 6;
  // Input fault summary layout
  localparam int B_IN_UV = 4;
  localparam int B_IN_OV = 7;
  localparam int B_IN_CP = 1;
  // Vendor fault summary layout
  localparam int B_VF_PRESET = 0;
  localparam int B_VF_CB = 1;
  // Setup register layout
  localparam int B_SU_CL_OVR = 0;
  localparam int B_SU_CL_VAL = 1;
  localparam int B_SU_CB_OVR = 2;
  localparam int B_SU_CB_VAL = 3;
  localparam int B_SU_RETRY_LO = 4;

  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  // Automatic restart: upward cycles between 1.7V and 1V
  localparam logic [3:0] RESTART_CYCLES = 4'h7;

  typedef enum logic [8:0] {
    ST_POR = 9'h001,
    ST_INSERT = 9'h002,
    ST_INS_DIS = 9'h004,
    ST_WAIT_UV = 9'h008,
    ST_ON = 9'h010,
    ST_BREAKER = 9'h020,
    ST_LATCHED = 9'h040,
    ST_RESTART = 9'h080,
    ST_LOCKOUT = 9'h100
  } hsf_state_t;

  // Gate pin drive: 190 mA pull-down, 2 mA pull-down, 22 uA source
  typedef struct packed {
    logic pd_strong;
    logic pd_weak;
    logic src;
  } hsf_gate_t;

  // Timer pin drive: ground, 5.5 uA, 90 uA, 2 mA sink, 2.8 uA sink
  typedef struct packed {
    logic gnd;
    logic chg_ins;
    logic chg_flt;
    logic dis_fast;
    logic dis_slow;
  } hsf_timer_t;
endpackage

// [core/hsf_sequencer.sv]
// Functional notes
// - Before power-on threshold, gate held off by 190 mA pull-down, timer grounded.
// - At power-on threshold, insertion starts: 5.5 uA timer charge, 2 mA gate pull-down.
// - Insertion ends at timer 1.7V, then timer discharged fast by 2 mA sink.
// - After insertion, gate turns on once input is above under-voltage level.
// - Gate is driven by the 22 uA source while on.
// - Limiting charges fault timer; ending early discharges it with 2.8 uA sink.
// - In-rush done when output is near input and power-good is high.
// - Timer at 1.7V under persisting limiting declares fault, 190 mA pull-down.
// - After fault gate stays low; retry input high latches, low auto-retries.
// - Retry count selectable: none, 1, 2, 4, 8, 16 or unlimited.
// - Input below under-voltage or above over-voltage switches gate off via 2 mA.
// - Alert line pulled low after power-on to flag default settings.
// - Defaults-loaded flag at 80h set after power-on until clear-faults command.
// - Current-limit threshold 25 mV with select low, 46 mV with select high.
// - Limiting beyond timeout sets current/power fault in 7Ch, E1h; alert unless masked.
// - Setup register bits override pin current-limit and breaker choices.
// - Breaker trip at 1.8x or 3.6x: 190 mA pull-down, fault timeout begins.
// - Breaker release hands gate to limiting; timer at 1.7V still shuts off.
// - Breaker trip sets breaker fault in 80h and E1h; alert unless masked.
// - Auto restart cycles timer 1.7V/1V seven times, re-enables at 0.3V.
module hsf_sequencer
  import hsf_pkg::*;
#(
  parameter int SYNC_W = HSF_CMP_W
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [SYNC_W-1:0] I_CMP,
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [15:0] I_REG_WDATA,
  input wire logic I_CLEAR_FAULTS,
  output logic [15:0] O_REG_RDATA,
  output hsf_gate_t O_GATE,
  output hsf_timer_t O_TIMER,
  output logic O_CL_HIGH,
  output logic O_CB_HIGH,
  output logic O_INRUSH_DONE,
  output logic O_ALERT_O,
  output logic O_ALERT_OE
);

  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] cmp_reg;
  hsf_state_t state_reg;
  hsf_state_t state_next;
  logic [15:0] mask_reg;
  logic [7:0] setup_reg;
  logic [3:0] cycle_reg;
  logic falling_reg;
  logic [4:0] tries_reg;
  logic inrush_reg;
  logic f_cp_reg, f_cb_reg, f_uv_reg, f_ov_reg, f_preset_reg;
  logic limiting, timeout, retry_inf, retry_exhausted;
  logic [4:0] retry_budget;
  logic [15:0] comb_word;
  hsf_gate_t gate_next;
  hsf_timer_t timer_next;

  // Retry code to budget; code 0 follows the retry pin
  function automatic logic [5:0] hsf_retry_decode(input logic [2:0] code, input logic pin_n);
    unique case (code)
      3'h0: hsf_retry_decode = pin_n ? 6'h00 : 6'h20;
      3'h1: hsf_retry_decode = 6'h00;
      3'h2: hsf_retry_decode = 6'h01;
      3'h3: hsf_retry_decode = 6'h02;
      3'h4: hsf_retry_decode = 6'h04;
      3'h5: hsf_retry_decode = 6'h08;
      3'h6: hsf_retry_decode = 6'h10;
      default: hsf_retry_decode = 6'h20;
    endcase
  endfunction

  // Two-stage synchroniser; only the second stage is read
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_sync
      always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          meta_reg[g] <= 1'b0;
          cmp_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= I_CMP[g];
          cmp_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign limiting = cmp_reg[IX_ILIM] | cmp_reg[IX_PLIM];
  assign timeout = cmp_reg[IX_TMR_HI];
  assign {retry_inf, retry_budget} = hsf_retry_decode(setup_reg[B_SU_RETRY_LO +: 3], cmp_reg[IX_RETRY_N]);
  assign retry_exhausted = !retry_inf && (tries_reg >= retry_budget);

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_POR: if (cmp_reg[IX_POR]) state_next = ST_INSERT;
      ST_INSERT: if (timeout) state_next = ST_INS_DIS;
      ST_INS_DIS: if (!cmp_reg[IX_TMR_LOW]) state_next = ST_WAIT_UV;
      ST_WAIT_UV: if (cmp_reg[IX_UV_OK] && !cmp_reg[IX_OV_HI]) state_next = ST_ON;
      ST_ON: begin
        if (!cmp_reg[IX_UV_OK] || cmp_reg[IX_OV_HI]) state_next = ST_LOCKOUT;
        else if (cmp_reg[IX_CB]) state_next = ST_BREAKER;
        else if (timeout && limiting) state_next = retry_exhausted ? ST_LATCHED : ST_RESTART;
      end
      ST_BREAKER: begin
        if (timeout) state_next = retry_exhausted ? ST_LATCHED : ST_RESTART;
        else if (!cmp_reg[IX_CB]) state_next = ST_ON;
      end
      ST_LATCHED: if (!cmp_reg[IX_UV_OK] && !cmp_reg[IX_TMR_LOW]) state_next = ST_WAIT_UV;
      ST_RESTART: begin
        if (falling_reg && cycle_reg == RESTART_CYCLES && !cmp_reg[IX_TMR_LOW]) state_next = ST_ON;
      end
      ST_LOCKOUT: if (cmp_reg[IX_UV_OK] && !cmp_reg[IX_OV_HI]) state_next = ST_ON;
      default: state_next = ST_POR;
    endcase
    // Losing the supply restarts the whole power-up sequence
    if (!cmp_reg[IX_POR]) state_next = ST_POR;
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) state_reg <= ST_POR;
    else state_reg <= state_next;
  end

  // Restart ramp tracking: count downward ramps that stop at 1V
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cycle_reg <= 4'h0;
      falling_reg <= 1'b0;
    end else if (state_reg != ST_RESTART) begin
      cycle_reg <= 4'h0;
      falling_reg <= 1'b1;
    end else if (falling_reg && cycle_reg != RESTART_CYCLES && !cmp_reg[IX_TMR_MID]) begin
      falling_reg <= 1'b0;
      cycle_reg <= cycle_reg + 4'h1;
    end else if (!falling_reg && timeout) begin
      falling_reg <= 1'b1;
    end
  end

  // Attempt counter; a fresh power-up or a manual restart refills it
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) tries_reg <= 5'h00;
    else if (state_reg == ST_POR || state_reg == ST_LATCHED) tries_reg <= 5'h00;
    else if (state_reg == ST_RESTART && state_next == ST_ON && tries_reg != 5'h1f) tries_reg <= tries_reg + 5'h01;
  end

  // In-rush completion, dropped whenever the gate leaves normal operation
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) inrush_reg <= 1'b0;
    else if (state_reg != ST_ON) inrush_reg <= 1'b0;
    else if (cmp_reg[IX_PGOOD]) inrush_reg <= 1'b1;
  end

  // Pin drive decode; registered so pins never glitch on state decode
  always_comb begin
    gate_next = '0;
    timer_next = '0;
    unique case (state_reg)
      ST_POR: begin
        gate_next.pd_strong = 1'b1;
        timer_next.gnd = 1'b1;
      end
      ST_INSERT: begin
        gate_next.pd_weak = 1'b1;
        timer_next.chg_ins = 1'b1;
      end
      ST_INS_DIS: begin
        gate_next.pd_weak = 1'b1;
        timer_next.dis_fast = 1'b1;
      end
      ST_WAIT_UV, ST_LOCKOUT: begin
        gate_next.pd_weak = 1'b1;
        timer_next.dis_slow = 1'b1;
      end
      ST_ON: begin
        gate_next.src = 1'b1;
        timer_next.chg_flt = limiting;
        timer_next.dis_slow = !limiting;
      end
      ST_BREAKER: begin
        gate_next.pd_strong = 1'b1;
        timer_next.chg_flt = 1'b1;
      end
      ST_LATCHED: begin
        // Strong pull-down only while the fault level is still present
        gate_next.pd_strong = timeout;
        gate_next.pd_weak = !timeout;
        timer_next.dis_slow = 1'b1;
      end
      ST_RESTART: begin
        gate_next.pd_strong = timeout && falling_reg && cycle_reg == 4'h0;
        gate_next.pd_weak = !(timeout && falling_reg && cycle_reg == 4'h0);
        timer_next.chg_flt = !falling_reg;
        timer_next.dis_slow = falling_reg;
      end
      default: gate_next.pd_strong = 1'b1;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_GATE <= '{pd_strong: 1'b1, pd_weak: 1'b0, src: 1'b0};
      O_TIMER <= '{gnd: 1'b1, chg_ins: 1'b0, chg_flt: 1'b0, dis_fast: 1'b0, dis_slow: 1'b0};
    end else begin
      O_GATE <= gate_next;
      O_TIMER <= timer_next;
    end
  end

  // Sticky fault flags: a new event wins over a clear in the same cycle
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      f_cp_reg <= 1'b0;
      f_cb_reg <= 1'b0;
      f_uv_reg <= 1'b0;
      f_ov_reg <= 1'b0;
      f_preset_reg <= 1'b0;
    end else begin
      f_cp_reg <= (f_cp_reg && !I_CLEAR_FAULTS) || (state_reg == ST_ON && timeout && limiting);
      f_cb_reg <= (f_cb_reg && !I_CLEAR_FAULTS) || (state_reg == ST_ON && state_next == ST_BREAKER);
      f_uv_reg <= (f_uv_reg && !I_CLEAR_FAULTS) || (state_reg == ST_ON && !cmp_reg[IX_UV_OK]);
      f_ov_reg <= (f_ov_reg && !I_CLEAR_FAULTS) || (state_reg == ST_ON && cmp_reg[IX_OV_HI]);
      f_preset_reg <= (f_preset_reg && !I_CLEAR_FAULTS) || (state_reg == ST_POR && cmp_reg[IX_POR]);
    end
  end

  // Software writable registers
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      mask_reg <= MASK_RESET;
      setup_reg <= SETUP_RESET;
    end else if (I_REG_WR) begin
      if (I_REG_ADDR == ADDR_ALERT_MASK) mask_reg <= I_REG_WDATA;
      if (I_REG_ADDR == ADDR_SETUP) setup_reg <= I_REG_WDATA[7:0];
    end
  end

  always_comb begin
    comb_word = 16'h0000;
    comb_word[B_CP_FAULT] = f_cp_reg;
    comb_word[B_BREAKER_FAULT_FLAG] = f_cb_reg;
    comb_word[B_UV_FAULT] = f_uv_reg;
    comb_word[B_OV_FAULT] = f_ov_reg;
    comb_word[B_LATCHED] = state_reg == ST_LATCHED;
    comb_word[B_PGOOD] = cmp_reg[IX_PGOOD];
    comb_word[B_PRESET] = f_preset_reg;
  end

  // Read port; unmapped codes read zero
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) O_REG_RDATA <= 16'h0000;
    else begin
      O_REG_RDATA <= 16'h0000;
      unique case (I_REG_ADDR)
        ADDR_INPUT_FAULT: begin
          O_REG_RDATA[B_IN_CP] <= f_cp_reg;
          O_REG_RDATA[B_IN_UV] <= f_uv_reg;
          O_REG_RDATA[B_IN_OV] <= f_ov_reg;
        end
        ADDR_VENDOR_FAULT: begin
          O_REG_RDATA[B_VF_PRESET] <= f_preset_reg;
          O_REG_RDATA[B_VF_CB] <= f_cb_reg;
        end
        ADDR_ALERT_MASK: O_REG_RDATA <= mask_reg;
        ADDR_SETUP: O_REG_RDATA[7:0] <= setup_reg;
        ADDR_COMBINED: O_REG_RDATA <= comb_word;
        default: O_REG_RDATA <= 16'h0000;
      endcase
    end
  end

  // Threshold selects and alert; the status bits themselves are never masked
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CL_HIGH <= 1'b0;
      O_CB_HIGH <= 1'b0;
      O_ALERT_OE <= 1'b0;
    end else begin
      O_CL_HIGH <= setup_reg[B_SU_CL_OVR] ? setup_reg[B_SU_CL_VAL] : cmp_reg[IX_CL_PIN];
      O_CB_HIGH <= setup_reg[B_SU_CB_OVR] ? setup_reg[B_SU_CB_VAL] : cmp_reg[IX_CB_PIN];
      O_ALERT_OE <= |(comb_word & ~mask_reg & ~(16'h0001 << B_PGOOD) & ~(16'h0001 << B_LATCHED));
    end
  end

  assign O_ALERT_O = 1'b0;
  assign O_INRUSH_DONE = inrush_reg;

  default clocking cb_main @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  property p_por_hold;
    !cmp_reg[IX_POR] |=> ##1 (O_GATE.pd_strong && O_TIMER.gnd);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("gate or timer not held at power-on");

  property p_insert;
    state_reg == ST_INSERT |=> O_TIMER.chg_ins && O_GATE.pd_weak && !O_GATE.src;
  endproperty
  a_insert: assert property (p_insert) else $error("insertion drive wrong");

  property p_ins_end;
    state_reg == ST_INSERT && timeout && cmp_reg[IX_POR] |=> state_reg == ST_INS_DIS ##1 O_TIMER.dis_fast;
  endproperty
  a_ins_end: assert property (p_ins_end) else $error("insertion did not end at timer level");

  property p_turn_on;
    state_reg == ST_WAIT_UV && cmp_reg[IX_UV_OK] && !cmp_reg[IX_OV_HI] && cmp_reg[IX_POR] |=> ##1 O_GATE.src;
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("gate not enabled above under-voltage");

  property p_src_on;
    O_GATE.src |-> $past(state_reg) == ST_ON && !O_GATE.pd_strong && !O_GATE.pd_weak;
  endproperty
  a_src_on: assert property (p_src_on) else $error("gate source outside normal operation");

  property p_timer_ctl;
    state_reg == ST_ON |=> O_TIMER.chg_flt == $past(limiting) && O_TIMER.dis_slow == !$past(limiting);
  endproperty
  a_timer_ctl: assert property (p_timer_ctl) else $error("fault timer drive wrong");

  property p_inrush;
    state_reg == ST_ON && cmp_reg[IX_PGOOD] |=> O_INRUSH_DONE;
  endproperty
  a_inrush: assert property (p_inrush) else $error("in-rush completion missed");

  property p_fault;
    state_reg == ST_ON && timeout && limiting && cmp_reg[IX_UV_OK] && !cmp_reg[IX_OV_HI]
      && !cmp_reg[IX_CB] && cmp_reg[IX_POR] |=> f_cp_reg ##1 !O_GATE.src;
  endproperty
  a_fault: assert property (p_fault) else $error("timeout did not shut the gate");

  property p_latch;
    state_reg == ST_LATCHED && cmp_reg[IX_UV_OK] && cmp_reg[IX_POR] |=> state_reg == ST_LATCHED;
  endproperty
  a_latch: assert property (p_latch) else $error("latched fault left without restart");

  property p_lockout;
    state_reg == ST_ON && cmp_reg[IX_OV_HI] && cmp_reg[IX_POR] |=> ##1 O_GATE.pd_weak && !O_GATE.src;
  endproperty
  a_lockout: assert property (p_lockout) else $error("over-voltage did not switch gate off");

  property p_sticky;
    f_preset_reg && !I_CLEAR_FAULTS |=> f_preset_reg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("defaults flag dropped without clear");

  property p_breaker;
    state_reg == ST_BREAKER |=> O_GATE.pd_strong && O_TIMER.chg_flt;
  endproperty
  a_breaker: assert property (p_breaker) else $error("breaker drive wrong");

  property p_alert;
    f_cb_reg && !mask_reg[B_BREAKER_FAULT_FLAG] |=> O_ALERT_OE;
  endproperty
  a_alert: assert property (p_alert) else $error("breaker flag not on alert line");

  property p_restart;
    state_reg == ST_RESTART && state_next == ST_ON |-> cycle_reg == RESTART_CYCLES;
  endproperty
  a_restart: assert property (p_restart) else $error("restart re-enabled early");

  c_power_up: cover property (state_reg == ST_WAIT_UV ##[1:20] state_reg == ST_ON);
  c_breaker: cover property (state_reg == ST_BREAKER ##1 state_reg == ST_ON);
  c_restart: cover property (state_reg == ST_RESTART ##[1:1000] state_reg == ST_ON);
  c_latched: cover property (state_reg == ST_LATCHED);

endmodule

// [verification/hsf_partner_model.sv]
// Timer capacitor and alert pull-up on the far side of the sequencer pins
module hsf_partner_model
  import hsf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire hsf_timer_t i_timer,
  input wire logic i_alert_o,
  input wire logic i_alert_oe,
  output logic o_tmr_hi,
  output logic o_tmr_mid,
  output logic o_tmr_low,
  output logic o_alert_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int mv;
  int mv_next;

  // Capacitor voltage in mV; steps are coarse so a whole restart run stays short
  always_comb begin
    mv_next = mv + (i_timer.chg_ins ? 10 : 0) + (i_timer.chg_flt ? 50 : 0);
    mv_next = mv_next - (i_timer.dis_fast ? 100 : 0) - (i_timer.dis_slow ? 20 : 0);
    if (i_timer.gnd || mv_next < 0) begin
      mv_next = 0;
    end else if (mv_next > 2500) begin
      mv_next = 2500; // Clamp at the charge source compliance
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mv <= 0;
    end else begin
      mv <= mv_next;
    end
  end

  // Level comparators and the pulled-up open-drain alert line
  assign o_tmr_hi = (mv >= 1700);
  assign o_tmr_mid = (mv >= 1000);
  assign o_tmr_low = (mv >= 300);
  assign o_alert_line = i_alert_oe ? i_alert_o : 1'b1;
endmodule

// [verification/hsf_sequencer_tb_top.sv]
module hsf_sequencer_tb_top
  import hsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 60000;
  localparam int P_SRC = 0, P_PDS = 1, P_PDW = 2, P_INS = 3, P_DISF = 4, P_FLT = 5, P_DISS = 6, P_INR = 7, P_ALR = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b0, uv_ok = 1'b0, ov_hi = 1'b0, ilim = 1'b0, plim = 1'b0, cb = 1'b0, pgood = 1'b0;
  logic retry_n = 1'b0, cl_pin = 1'b0, cb_pin = 1'b0, reg_wr = 1'b0, clr = 1'b0;
  logic tmr_hi, tmr_mid, tmr_low, alert_line, cl_high, cb_high, inrush, alert_o, alert_oe;
  logic src_d = 1'b0, flt_d = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] rdata, v;
  hsf_gate_t gate;
  hsf_timer_t tmr;
  int failures = 0, n_compared = 0, cycles = 0, rises = 0, pulses = 0;
  int exp_n[6] = '{0, 1, 2, 4, 8, 16};

  always #2.5 clk = ~clk;

  hsf_sequencer DUT (
    .I_CLK(clk), .I_RST(rst),
    .I_CMP({alert_line, cb_pin, cl_pin, retry_n, pgood, cb, plim, ilim, tmr_low, tmr_mid, tmr_hi, ov_hi, uv_ok, por}),
    .I_REG_WR(reg_wr), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .I_CLEAR_FAULTS(clr),
    .O_REG_RDATA(rdata), .O_GATE(gate), .O_TIMER(tmr), .O_CL_HIGH(cl_high), .O_CB_HIGH(cb_high),
    .O_INRUSH_DONE(inrush), .O_ALERT_O(alert_o), .O_ALERT_OE(alert_oe)
  );

  hsf_partner_model u_far (
    .i_clk(clk), .i_rst(rst), .i_timer(tmr), .i_alert_o(alert_o), .i_alert_oe(alert_oe),
    .o_tmr_hi(tmr_hi), .o_tmr_mid(tmr_mid), .o_tmr_low(tmr_low), .o_alert_line(alert_line)
  );

  // Edge counts of gate turn-on and fault charging, plus the hang guard
  always @(posedge clk) begin
    src_d <= gate.src;
    flt_d <= tmr.chg_flt;
    if (gate.src && !src_d) rises++;
    if (tmr.chg_flt && !flt_d) pulses++;
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Outputs are sampled 1 ns after the edge so the edge's updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    settle(2);
  endtask

  // Read data is registered from the address of the previous cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    settle(2);
    d = rdata;
  endtask

  task automatic clear_faults();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    settle(3);
  endtask

  function automatic logic probe(input int sel);
    case (sel)
      P_SRC: return gate.src;
      P_PDS: return gate.pd_strong;
      P_PDW: return gate.pd_weak;
      P_INS: return tmr.chg_ins;
      P_DISF: return tmr.dis_fast;
      P_FLT: return tmr.chg_flt;
      P_DISS: return tmr.dis_slow;
      P_INR: return inrush;
      default: return alert_oe;
    endcase
  endfunction

  // Bounded wait for an output level, then a comparison on it
  task automatic wait_sig(input string what, input int sel, input logic val, input int lim);
    for (int k = 0; k < lim && probe(sel) !== val; k++) begin
      settle(1);
    end
    chk(what, 16'(probe(sel)), 16'(val));
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(10);
    chk("gate strong pull-down", 16'(gate.pd_strong), 16'h0001);
    chk("timer grounded", 16'(tmr.gnd), 16'h0001);
    chk("alert data", 16'(alert_o), 16'h0000);
    rd(ADDR_ALERT_MASK, v);
    chk("mask reset", v, MASK_RESET);
    rd(ADDR_SETUP, v);
    chk("setup reset", v, 16'(SETUP_RESET));
    wr(ADDR_INPUT_FAULT, 16'hffff);
    rd(ADDR_INPUT_FAULT, v);
    chk("read-only input summary", v, 16'h0000);
    rd(8'h55, v);
    chk("unmapped read", v, 16'h0000);
    // Power-up with the input still below the under-voltage level
    @(posedge clk) por <= 1'b1;
    wait_sig("insertion charge", P_INS, 1'b1, 10);
    chk("insertion weak pull-down", 16'({gate.pd_strong, gate.pd_weak, gate.src}), 16'h0002);
    wait_sig("defaults alert", P_ALR, 1'b1, 10);
    rd(ADDR_VENDOR_FAULT, v);
    chk("defaults flag", v, 16'h0001);
    wait_sig("insertion end discharge", P_DISF, 1'b1, 400);
    settle(40);
    chk("held off below uv", 16'(gate.src), 16'h0000);
    @(posedge clk) uv_ok <= 1'b1;
    wait_sig("gate on", P_SRC, 1'b1, 10);
    chk("weak released", 16'(gate.pd_weak), 16'h0000);
    // Threshold selects from pins, then from setup overrides
    @(posedge clk) cl_pin <= 1'b1;
    settle(8);
    chk("limit select high", 16'(cl_high), 16'h0001);
    @(posedge clk) cl_pin <= 1'b0;
    cb_pin <= 1'b1;
    settle(8);
    chk("limit select low", 16'(cl_high), 16'h0000);
    chk("breaker select high", 16'(cb_high), 16'h0001);
    wr(ADDR_SETUP, 16'h0007);
    chk("limit override", 16'({cl_high, cb_high}), 16'h0002);
    wr(ADDR_SETUP, 16'h0000);
    @(posedge clk) cb_pin <= 1'b0;
    @(posedge clk) pgood <= 1'b1;
    wait_sig("inrush done", P_INR, 1'b1, 10);
    // Short power limiting, ended well before the timer level
    @(posedge clk) plim <= 1'b1;
    wait_sig("fault timer charge", P_FLT, 1'b1, 10);
    @(posedge clk) plim <= 1'b0;
    wait_sig("fault timer bleed", P_DISS, 1'b1, 10);
    chk("still on", 16'({gate.src, tmr.chg_flt}), 16'h0002);
    // Breaker trip and release
    @(posedge clk) cb <= 1'b1;
    wait_sig("breaker pull-down", P_PDS, 1'b1, 10);
    chk("breaker timer", 16'({gate.src, tmr.chg_flt}), 16'h0001);
    @(posedge clk) cb <= 1'b0;
    wait_sig("breaker released", P_SRC, 1'b1, 10);
    rd(ADDR_VENDOR_FAULT, v);
    chk("breaker flag 80h", v, 16'h0003);
    rd(ADDR_COMBINED, v);
    chk("breaker flag e1h", v, 16'h0062);
    clear_faults();
    rd(ADDR_COMBINED, v);
    chk("flags cleared", v, 16'h0020);
    wait_sig("alert released", P_ALR, 1'b0, 5);
    // Masked current fault, automatic restart with the pin low
    wr(ADDR_ALERT_MASK, 16'h0001);
    @(posedge clk) ilim <= 1'b1;
    wait_sig("timeout pull-down", P_PDS, 1'b1, 200);
    pulses = 0;
    @(posedge clk) ilim <= 1'b0;
    rd(ADDR_INPUT_FAULT, v);
    chk("current fault 7ch", v, 16'h0002);
    rd(ADDR_COMBINED, v);
    chk("current fault e1h", v & 16'h0013, 16'h0001);
    chk("masked alert", 16'(alert_oe), 16'h0000);
    wait_sig("restart turn-on", P_SRC, 1'b1, 2000);
    chk("restart cycles", 16'(pulses), 16'h0007);
    clear_faults();
    wr(ADDR_ALERT_MASK, 16'h0000);
    // Each finite retry code: count turn-ons until latched off
    wr(ADDR_SETUP, 16'h0010);
    for (int i = 0; i < 6; i++) begin
      rises = 0;
      v = 16'h0000;
      @(posedge clk) ilim <= 1'b1;
      // Sixteen retries take close to 10k cycles, each poll costs three
      for (int k = 0; k < 5000 && v[B_LATCHED] !== 1'b1; k++) rd(ADDR_COMBINED, v);
      @(posedge clk) ilim <= 1'b0;
      chk("latched bit", 16'(v[B_LATCHED]), 16'h0001);
      chk("current fault alert", 16'(alert_oe), 16'h0001);
      chk("retry count", 16'(rises), 16'(exp_n[i]));
      settle(40);
      chk("latched gate off", 16'(gate.src), 16'h0000);
      if (i < 5) wr(ADDR_SETUP, 16'((i + 2) << 4));
      @(posedge clk) uv_ok <= 1'b0;
      for (int k = 0; k < 300 && tmr_low !== 1'b0; k++) settle(1);
      settle(8);
      @(posedge clk) uv_ok <= 1'b1;
      wait_sig("latched restart", P_SRC, 1'b1, 20);
      clear_faults();
    end
    wr(ADDR_SETUP, 16'h0000);
    // Input window faults while on
    @(posedge clk) ov_hi <= 1'b1;
    wait_sig("over-voltage off", P_PDW, 1'b1, 10);
    chk("over-voltage gate", 16'(gate.src), 16'h0000);
    rd(ADDR_INPUT_FAULT, v);
    chk("over-voltage flag", v, 16'h0080);
    @(posedge clk) ov_hi <= 1'b0;
    wait_sig("over-voltage recover", P_SRC, 1'b1, 10);
    @(posedge clk) uv_ok <= 1'b0;
    wait_sig("under-voltage off", P_PDW, 1'b1, 10);
    rd(ADDR_INPUT_FAULT, v);
    chk("under-voltage flag", v, 16'h0090);
    @(posedge clk) por <= 1'b0;
    wait_sig("power lost", P_PDS, 1'b1, 10);
    chk("timer grounded again", 16'(tmr.gnd), 16'h0001);
    report_and_stop();
  end
endmodule
